// ===== test/phy_model.sv
// behavioural model of the external phy pins
`timescale 1ns/1ps
module phy_model #(
   parameter int DELAY = 2  // cycles from command to pin
) (
   // clock
   input  wire logic aclk,
   // commands from the bench
   input  wire logic link_up,
   input  wire logic carrier_on,
   // pins toward the mac
   output logic      link_status_pin,
   output logic      carrier_sense_pin
);
   logic [DELAY-1:0] lk = '0;  // link delay line
   logic [DELAY-1:0] cr = '0;  // carrier delay line
   // pins follow the commands after a short, fixed delay of DELAY cycles
   always_ff @(posedge aclk) begin
      lk <= {lk[DELAY-2:0], link_up};
      cr <= {cr[DELAY-2:0], carrier_on};
   end
   // link pin is low while the link is up
   assign link_status_pin   = ~lk[DELAY-1];
   assign carrier_sense_pin = cr[DELAY-1];
endmodule : phy_model

// ===== test/stat_monitor.sv
// bus and register-read checks for the statistics block
`timescale 1ns/1ps
`include "stat_defs.svh"
module stat_monitor #(
   parameter int ADDR_W = 8
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [1:0]        bresp,
   input wire logic              bvalid,
   input wire logic              bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [31:0]       rdata,
   input wire logic              rvalid,
   input wire logic              link_status_pin
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] stab;  // cycles the link pin has held its level
   // count quiet cycles of the link pin, saturating
   always_ff @(posedge aclk) begin
      if (!aresetn || $changed(link_status_pin)) stab <= 4'h0;
      else if (stab != 4'hF) stab <= stab + 4'h1;
   end
   sequence s_wr_take;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rd_take;
      arvalid && arready;
   endsequence
   a_write_answer: assert property (s_wr_take |=> ##1 bvalid)
      else $error("write not answered");
   a_bresp_once: assert property (bvalid && bready |=> !bvalid)
      else $error("write answer repeated");
   a_read_answer: assert property (s_rd_take |=> rvalid)
      else $error("read not answered");
   a_link_upper: assert property ((s_rd_take and araddr[ADDR_W-1:2] == 0) |=> rdata[31:1] == 0)
      else $error("link register upper bits set");
   a_link_mirror: assert property ((s_rd_take and araddr[ADDR_W-1:2] == 0 and stab >= 8)
      |=> rdata[0] == !$past(link_status_pin))
      else $error("link bit not inverse of pin");
   a_cnt_upper: assert property ((s_rd_take and araddr[ADDR_W-1:2] inside {1, [3:7]})
      |=> rdata[31:16] == 16'h0000)
      else $error("counter upper bits set");
   a_unmapped_err: assert property ((s_wr_take and awaddr[ADDR_W-1:2] > 10)
      |=> ##1 bresp == `RESP_SLVERR)
      else $error("unmapped write not refused");
   a_mapped_ok: assert property ((s_wr_take and awaddr[ADDR_W-1:2] <= 10)
      |=> ##1 bresp == `RESP_OKAY)
      else $error("mapped write refused");
endmodule : stat_monitor
bind ethernet_stat_counters stat_monitor #(.ADDR_W(ADDR_W)) mon (.aclk(aclk), .aresetn(aresetn),
   .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rvalid(rvalid), .link_status_pin(link_status_pin));

// ===== test/tb.sv
// self-checking bench for the statistics block
`timescale 1ns/1ps
`include "stat_defs.svh"
module tb;
   import eth_stat_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [3:0] wstrb = 4'hF;
   logic [3:0] ev = '0;  // retry, collision, tx start, rx done
   logic crc_bad = 1, tda = 0, tick = 0, pre = 0, link_up = 0, carrier_on = 0;
   word_t wdata = '0, rdata;
   resp_t bresp, rresp, r;
   cnt16_t tx_len = 16'h0040;
   logic awready, wready, bvalid, arready, rvalid, irq, lpin, cpin;
   int num_errors = 0, n_compared = 0, cyc = 0;
   word_t d;
   always #5 aclk = ~aclk;
   phy_model phy (.aclk(aclk), .link_up(link_up), .carrier_on(carrier_on),
      .link_status_pin(lpin), .carrier_sense_pin(cpin));
   ethernet_stat_counters DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .link_status_pin(lpin), .carrier_sense_pin(cpin),
      .retry_abandon(ev[0]), .collision_seen(ev[1]), .tx_data_active(tda), .tx_bit_tick(tick),
      .tx_preamble_active(pre), .tx_start(ev[2]), .tx_length(tx_len),
      .rx_frame_done(ev[3]), .rx_crc_bad(crc_bad), .irq(irq));
   task automatic tally_and_finish();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   // cut a hang short
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 90000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input word_t seen, input word_t exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one axi4-lite write, waits for the response
   task automatic wr(input logic [7:0] a, input word_t v);
      @(posedge aclk);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      r = bresp;
      bready <= 0;
   endtask : wr
   // one axi4-lite read, waits for the data
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      d = rdata; r = rresp;
      rready <= 0;
   endtask : rd
   task automatic pulse(input int b, input int n);
      repeat (n) begin
         @(posedge aclk); ev[b] <= 1;
         @(posedge aclk); ev[b] <= 0;
      end
   endtask : pulse
   task automatic t_map();
      for (int i = 1; i < 8; i++) begin
         rd(8'(4 * i)); chk(d, 32'h0);
      end
      rd(8'h30); chk(32'(r), 32'h2);
      wr(8'h30, 32'h0); chk(32'(r), 32'h2);
   endtask : t_map
   task automatic t_link();
      link_up <= 1; repeat (12) @(posedge aclk);
      rd(`OFF_LINK); chk(d, 32'h1);
      link_up <= 0; repeat (12) @(posedge aclk);
      rd(`OFF_LINK); chk(d, 32'h0);
   endtask : t_link
   task automatic t_events();
      pulse(0, 3); rd(`OFF_RETRY); chk(d, 32'h3);
      tx_len <= 16'h0003; pulse(2, 1); tx_len <= 16'h0004; pulse(2, 1);
      rd(`OFF_SHORT); chk(d, 32'h1);
      pulse(3, 2); crc_bad <= 0; pulse(3, 1);
      rd(`OFF_CRC); chk(d, 32'h2);
      crc_bad <= 1; wr(`OFF_MODE, 32'h1); pulse(3, 1); wr(`OFF_MODE, 32'h0);
      rd(`OFF_CRC); chk(d, 32'h2);
      @(posedge aclk); tda <= 1; tick <= 1;
      repeat (511) @(posedge aclk);
      tick <= 0; pulse(1, 1); tick <= 1; @(posedge aclk); tick <= 0; pulse(1, 1); tda <= 0;
      rd(`OFF_LATE); chk(d, 32'h1);
      rd(`OFF_COLL); chk(d, 32'h2);
      carrier_on <= 1; repeat (10) @(posedge aclk); tda <= 1;
      carrier_on <= 0; repeat (10) @(posedge aclk); tda <= 0;
      rd(`OFF_LOST); chk(d, 32'h1);
      @(posedge aclk); pre <= 1; repeat (10) @(posedge aclk); pre <= 0;
      rd(`OFF_NOCAR); chk(d, 32'h1);
   endtask : t_events
   task automatic t_clear();
      wr(`OFF_RETRY, 32'h0000BEEF); rd(`OFF_RETRY); chk(d, 32'h0);
      wr(`OFF_COLL, 32'h89ABCDEF); rd(`OFF_COLL); chk(d, 32'h0);
      pulse(0, 2);
      fork
         wr(`OFF_RETRY, 32'h0);
         begin
            // event sampled on the same edge that applies the clear
            repeat (2) @(posedge aclk);
            ev[0] <= 1; @(posedge aclk); ev[0] <= 0;
         end
      join
      rd(`OFF_RETRY); chk(d, 32'h0);
   endtask : t_clear
   task automatic t_sat();
      @(posedge aclk); ev[0] <= 1;
      repeat (65540) @(posedge aclk);
      ev[0] <= 0;
      rd(`OFF_RETRY); chk(d, 32'h0000FFFF);
   endtask : t_sat
   task automatic t_irq();
      wr(`OFF_IRQ_STAT, 32'hFF); wr(`OFF_IRQ_MASK, 32'h1);
      pulse(3, 1); repeat (2) @(posedge aclk); chk(32'(irq), 32'h0);
      pulse(0, 1); repeat (2) @(posedge aclk); chk(32'(irq), 32'h1);
      wr(`OFF_IRQ_STAT, 32'h1); repeat (2) @(posedge aclk); chk(32'(irq), 32'h0);
   endtask : t_irq
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      t_map();
      t_link();
      t_events();
      t_clear();
      t_sat();
      t_irq();
      tally_and_finish();
   end
endmodule : tb

// ===== verilog/eth_stat_pkg.sv
// types shared by the statistics block files
package eth_stat_pkg;
   typedef logic [31:0] word_t;      // bus data word
   typedef logic [7:0]  irq_bits_t;  // interrupt status and mask layout
   typedef logic [15:0] cnt16_t;     // narrow counter value
   typedef logic [1:0]  resp_t;      // bus response code
endpackage : eth_stat_pkg

// ===== verilog/ethernet_stat_counters.sv
// link monitor and transmit/receive statistics counters with an AXI4-Lite port
//
// What this block does
// - link bit reads inverse of link pin
// - link register bits above bit zero read zero
// - count frames abandoned after sixteen attempts
// - sixteen-bit counters hold at maximum value
// - any write clears a counter
// - 32-bit collision counter counts all, saturates; the code holds it at COLL_SAT, 0x0FFFFFFF
// - any write clears collision counter
// - late count only after 512 bit times
// - count carrier drop during frame transmission
// - count carrier absent during preamble
// - count transmit attempts shorter than four bytes
// - count received frames with bad check sequence
// - accept-error mode stops the error count
// - upper counter bits read zero, write zero
`timescale 1ns/1ps
`include "stat_defs.svh"
module ethernet_stat_counters #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0]     awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   // axi4-lite write data
   input  wire eth_stat_pkg::word_t   wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   // axi4-lite write response
   output eth_stat_pkg::resp_t        bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0]     araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   // axi4-lite read data
   output eth_stat_pkg::word_t        rdata,
   output eth_stat_pkg::resp_t        rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // phy pins
   input  wire logic                  link_status_pin,
   input  wire logic                  carrier_sense_pin,
   // transmit engine events, same clock
   input  wire logic                  retry_abandon,
   input  wire logic                  collision_seen,
   input  wire logic                  tx_data_active,
   input  wire logic                  tx_bit_tick,
   input  wire logic                  tx_preamble_active,
   input  wire logic                  tx_start,
   input  wire eth_stat_pkg::cnt16_t  tx_length,
   // receive engine events, same clock
   input  wire logic                  rx_frame_done,
   input  wire logic                  rx_crc_bad,
   // interrupt
   output logic                       irq
);
   import eth_stat_pkg::*;

   // ---------------- pin synchronisers ----------------
   logic [2:0] link_pipe;   // link pin shift chain
   logic [2:0] crs_pipe;    // carrier pin shift chain
   logic       link_level;  // filtered link pin level
   logic       crs_level;   // filtered carrier level
   logic       crs_prev;    // carrier level one cycle back
   logic       link_prev;   // link level one cycle back

   // three stages; a level is accepted once stages two and three agree
   // link chain starts at the idle pin level so no false change follows reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_pipe <= {3{`LINK_IDLE}};
         crs_pipe  <= 3'h0;
      end else begin
         link_pipe <= {link_pipe[1:0], link_status_pin};
         crs_pipe  <= {crs_pipe[1:0], carrier_sense_pin};
      end
   end

   // filtered levels and their previous values
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_level <= `LINK_IDLE;
         crs_level  <= 1'b0;
         crs_prev   <= 1'b0;
         link_prev  <= `LINK_IDLE;
      end else begin
         if (link_pipe[1] == link_pipe[2]) begin
            link_level <= link_pipe[2];
         end
         if (crs_pipe[1] == crs_pipe[2]) begin
            crs_level <= crs_pipe[2];
         end
         crs_prev  <= crs_level;
         link_prev <= link_level;
      end
   end

   // link bit is the inverse of the pin level
   wire link_monitor_bit = ~link_level;
   wire link_changed     = link_level ^ link_prev;

   // ---------------- transmit timing ----------------
   logic [9:0] tx_bit_count;   // bit times since data start, held at limit
   logic       preamble_prev;  // preamble flag one cycle back
   logic       carrier_seen;   // carrier present at some point in preamble

   // count bit times while data is going out
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_bit_count <= 10'h000;
      end else if (!tx_data_active) begin
         tx_bit_count <= 10'h000;
      end else if (tx_bit_tick && (tx_bit_count != `LATE_BITS)) begin
         tx_bit_count <= tx_bit_count + 10'h001;
      end
   end

   // remember whether carrier showed up during the preamble
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         preamble_prev <= 1'b0;
         carrier_seen  <= 1'b0;
      end else begin
         preamble_prev <= tx_preamble_active;
         if (!tx_preamble_active) begin
            carrier_seen <= 1'b0;
         end else if (crs_level) begin
            carrier_seen <= 1'b1;
         end
      end
   end

   // ---------------- event decode ----------------
   logic      accept_crc_error_frames;  // mode bit
   wire       late_window  = (tx_bit_count == `LATE_BITS);
   wire       preamble_end = preamble_prev & ~tx_preamble_active;
   wire [`NUM_SLOTS-1:0] ev16;

   assign ev16[`SLOT_RETRY] = retry_abandon;
   assign ev16[`SLOT_LATE]  = collision_seen & late_window;
   assign ev16[`SLOT_LOST]  = crs_prev & ~crs_level & tx_data_active;
   assign ev16[`SLOT_NOCAR] = preamble_end & ~carrier_seen;
   assign ev16[`SLOT_SHORT] = tx_start & (tx_length < `MIN_TX_LEN);
   assign ev16[`SLOT_CRC]   = rx_frame_done & rx_crc_bad
                              & ~accept_crc_error_frames;

   // ---------------- axi write side ----------------
   logic              aw_full;   // write address held
   logic              w_full;    // write data held
   logic [ADDR_W-1:0] aw_addr_q; // held write address
   word_t             w_data_q;  // held write data
   logic [3:0]        w_strb_q;  // held byte enables

   wire aw_take  = awvalid & awready;
   wire w_take   = wvalid & wready;
   wire do_write = aw_full & w_full & ~bvalid;
   wire next_aw_full = aw_take | (aw_full & ~do_write);
   wire next_w_full  = w_take | (w_full & ~do_write);

   // capture address and data independently
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full   <= 1'b0;
         w_full    <= 1'b0;
         awready   <= 1'b1;
         wready    <= 1'b1;
         aw_addr_q <= '0;
         w_data_q  <= `WORD_ZERO;
         w_strb_q  <= 4'h0;
      end else begin
         aw_full <= next_aw_full;
         w_full  <= next_w_full;
         awready <= ~next_aw_full;
         wready  <= ~next_w_full;
         if (aw_take) begin
            aw_addr_q <= awaddr;
         end
         if (w_take) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
      end
   end

   // write target decode on the word address
   wire [7:0] wr_word   = {aw_addr_q[7:2], 2'b00};
   wire hit_w_link      = (wr_word == `OFF_LINK);
   wire hit_w_coll      = (wr_word == `OFF_COLL);
   wire hit_w_mode      = (wr_word == `OFF_MODE);
   wire hit_w_stat      = (wr_word == `OFF_IRQ_STAT);
   wire hit_w_mask      = (wr_word == `OFF_IRQ_MASK);
   wire [`NUM_SLOTS-1:0] hit_w16;
   assign hit_w16[`SLOT_RETRY] = (wr_word == `OFF_RETRY);
   assign hit_w16[`SLOT_LATE]  = (wr_word == `OFF_LATE);
   assign hit_w16[`SLOT_LOST]  = (wr_word == `OFF_LOST);
   assign hit_w16[`SLOT_NOCAR] = (wr_word == `OFF_NOCAR);
   assign hit_w16[`SLOT_SHORT] = (wr_word == `OFF_SHORT);
   assign hit_w16[`SLOT_CRC]   = (wr_word == `OFF_CRC);
   wire wr_mapped = hit_w_link | hit_w_coll | hit_w_mode | hit_w_stat
                    | hit_w_mask | (|hit_w16);
   wire low_lane  = w_strb_q[0];

   // write response, held until accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ---------------- control registers ----------------
   irq_bits_t irq_status;  // sticky event bits
   irq_bits_t irq_mask;    // enables for irq
   irq_bits_t irq_events;  // this cycle's events

   assign irq_events = {link_changed, collision_seen, ev16};

   // mode bit and mask, written through the low byte lane
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         accept_crc_error_frames <= 1'b0;
         irq_mask                <= `IRQ_ZERO;
      end else if (do_write && low_lane) begin
         if (hit_w_mode) begin
            accept_crc_error_frames <= w_data_q[`MODE_ACCEPT_CRC];
         end
         if (hit_w_mask) begin
            irq_mask <= w_data_q[7:0];
         end
      end
   end

   // sticky status: write one clears, a new event wins over the clear
   wire [7:0] stat_clear = (do_write && low_lane && hit_w_stat) ? w_data_q[7:0]
                                                                 : `IRQ_ZERO;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= `IRQ_ZERO;
      end else begin
         irq_status <= (irq_status & ~stat_clear) | irq_events;
      end
   end

   // level interrupt from a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_status & ~stat_clear) | irq_events) & irq_mask);
      end
   end

   // ---------------- counters ----------------
   cnt16_t count16 [`NUM_SLOTS];  // narrow counter values
   word_t  collision_count_all;   // wide collision counter value

   // any write to a counter clears it, whatever the data
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_SLOTS; gi++) begin : g_cnt
         sat_counter #(
            .WIDTH (16),
            .MAX   (`CNT16_SAT)
         ) u_cnt (
            .aclk    (aclk),
            .aresetn (aresetn),
            .clear   (do_write & hit_w16[gi]),
            .bump    (ev16[gi]),
            .count   (count16[gi])
         );
      end
   endgenerate

   // every collision since reset or the last write to it, wide counter held at 0x0FFFFFFF
   sat_counter #(
      .WIDTH (32),
      .MAX   (`COLL_SAT)
   ) u_coll (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (do_write & hit_w_coll),
      .bump    (collision_seen),
      .count   (collision_count_all)
   );

   // ---------------- axi read side ----------------
   wire [7:0] rd_word = {araddr[7:2], 2'b00};
   wire [`NUM_SLOTS-1:0] hit_r16;
   assign hit_r16[`SLOT_RETRY] = (rd_word == `OFF_RETRY);
   assign hit_r16[`SLOT_LATE]  = (rd_word == `OFF_LATE);
   assign hit_r16[`SLOT_LOST]  = (rd_word == `OFF_LOST);
   assign hit_r16[`SLOT_NOCAR] = (rd_word == `OFF_NOCAR);
   assign hit_r16[`SLOT_SHORT] = (rd_word == `OFF_SHORT);
   assign hit_r16[`SLOT_CRC]   = (rd_word == `OFF_CRC);
   wire hit_r_link = (rd_word == `OFF_LINK);
   wire hit_r_coll = (rd_word == `OFF_COLL);
   wire hit_r_mode = (rd_word == `OFF_MODE);
   wire hit_r_stat = (rd_word == `OFF_IRQ_STAT);
   wire hit_r_mask = (rd_word == `OFF_IRQ_MASK);
   wire rd_mapped  = hit_r_link | hit_r_coll | hit_r_mode | hit_r_stat
                     | hit_r_mask | (|hit_r16);

   // or together the narrow counters that match, upper half zero
   word_t rd16 [`NUM_SLOTS+1];
   assign rd16[0] = `WORD_ZERO;
   generate
      for (gi = 0; gi < `NUM_SLOTS; gi++) begin : g_rd
         assign rd16[gi+1] = rd16[gi]
                             | (hit_r16[gi] ? {16'h0000, count16[gi]}
                                            : `WORD_ZERO);
      end
   endgenerate

   // read data select; reserved bits are zero
   wire word_t rd_value =
      hit_r_link ? {31'h00000000, link_monitor_bit} :
      hit_r_coll ? collision_count_all :
      hit_r_mode ? {31'h00000000, accept_crc_error_frames} :
      hit_r_stat ? {24'h000000, irq_status} :
      hit_r_mask ? {24'h000000, irq_mask} :
      rd16[`NUM_SLOTS];

   wire ar_take = arvalid & arready;

   // one read at a time; address accepted, data presented next cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= `WORD_ZERO;
         rresp   <= `RESP_OKAY;
      end else if (ar_take) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_value;
         rresp   <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
      end
   end

endmodule : ethernet_stat_counters

// ===== verilog/sat_counter.sv
// saturating event counter cleared by a software write
`timescale 1ns/1ps
module sat_counter #(
   parameter int               WIDTH = 16,
   parameter logic [WIDTH-1:0] MAX   = '1
) (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // control
   input  wire logic             clear,
   input  wire logic             bump,
   // value
   output logic [WIDTH-1:0]      count
);
   // clear beats a same-cycle event, then count up to the limit and hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (bump && (count != MAX)) begin
         count <= count + 1'b1;
      end
   end
endmodule : sat_counter

// ===== verilog/stat_defs.svh
// offsets, field positions, reset values and limits of the statistics block
`ifndef ETH_STAT_DEFS_SVH
`define ETH_STAT_DEFS_SVH

// register byte offsets
`define OFF_LINK     8'h00
`define OFF_RETRY    8'h04
`define OFF_COLL     8'h08
`define OFF_LATE     8'h0C
`define OFF_LOST     8'h10
`define OFF_NOCAR    8'h14
`define OFF_SHORT    8'h18
`define OFF_CRC      8'h1C
`define OFF_MODE     8'h20
`define OFF_IRQ_STAT 8'h24
`define OFF_IRQ_MASK 8'h28

// 16-bit counter slots
`define SLOT_RETRY   0
`define SLOT_LATE    1
`define SLOT_LOST    2
`define SLOT_NOCAR   3
`define SLOT_SHORT   4
`define SLOT_CRC     5
`define NUM_SLOTS    6

// interrupt bit positions beyond the 16-bit slots
`define IRQ_COLL     6
`define IRQ_LINK     7

// field positions and limits
`define MODE_ACCEPT_CRC 0
`define CNT16_SAT    16'hFFFF
`define COLL_SAT     32'h0FFFFFFF
`define LATE_BITS    10'h200
`define MIN_TX_LEN   16'h0004
`define LINK_IDLE    1'b1

// bus answers and reset values
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define WORD_ZERO    32'h00000000
`define IRQ_ZERO     8'h00

`endif
